// ### design/ocam_regs.vh
`ifndef OCAM_REGS_VH
`define OCAM_REGS_VH
// Clock rate and derived cycle counts (250 MHz, 4 ns period).
`define OCAM_CLK_MHZ        250
`define OCAM_WIN_US         10
`define OCAM_WIN_CYC        (`OCAM_WIN_US * `OCAM_CLK_MHZ)
`define OCAM_DIS_US         20
`define OCAM_DIS_CYC        (`OCAM_DIS_US * `OCAM_CLK_MHZ)
`define OCAM_ENA_US         300
`define OCAM_ENA_CYC        (`OCAM_ENA_US * `OCAM_CLK_MHZ)
`define OCAM_CNT_W          17
// Delay setting codes and the consecutive window counts they need.
`define OCAM_DLY_10US       2'h0
`define OCAM_DLY_50US       2'h1
`define OCAM_DLY_100US      2'h2
`define OCAM_NWIN_10US      4'h1
`define OCAM_NWIN_50US      4'h5
`define OCAM_NWIN_100US     4'hA
// Power states.
`define OCAM_ST_OFF         2'h0
`define OCAM_ST_WAKE        2'h1
`define OCAM_ST_ON          2'h2
`define OCAM_ST_SLEEP       2'h3
`endif

// ### design/ocam_window.v
`include "ocam_regs.vh"

// Free-running comparison window: accumulates over-threshold samples and
// reports a one-cycle decision at the end of each window.
module ocam_window (
   input  wire        i_clk_sys,
   input  wire        i_rstn,
   input  wire        i_over,
   output reg         o_end,
   output reg         o_over_avg
);
   localparam [15:0] WIN_LAST = `OCAM_WIN_CYC - 1;
   localparam [15:0] HALF     = `OCAM_WIN_CYC / 2;

   reg [15:0] cnt_q;
   reg [15:0] acc_q;

   // The averaged input is taken as above threshold when more than half
   // of the window's samples were over.
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         cnt_q      <= 16'h0000;
         acc_q      <= 16'h0000;
         o_end      <= 1'b0;
         o_over_avg <= 1'b0;
      end else if (cnt_q == WIN_LAST) begin
         cnt_q      <= 16'h0000;
         acc_q      <= 16'h0000;
         o_end      <= 1'b1;
         o_over_avg <= ((acc_q + {15'h0000, i_over}) > HALF);
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         acc_q <= acc_q + {15'h0000, i_over};
         o_end <= 1'b0;
      end
   end
endmodule // ocam_window

// ### design/ocam_core.v
`include "ocam_regs.vh"

// Contract
// - With the latch-select input low the alert follows the window decision.
// - An overcurrent decision drives the active-low alert low.
// - In transparent mode one under-threshold window releases the alert.
// - In latch mode an asserted alert stays low after the input falls.
// - With latch-select low the alert releases only if the input is below, or when the device enters low power.
// - Enable falling puts the device into low power after about 20 us.
// - Enable rising restores active monitoring after about 300 us.
// - Disabling clears the consecutive-window counter, which restarts at 0.
// - A free-running 10 us window decides at its end if the input was over.
// - The alert needs 1, 5 or 10 consecutive over windows per the delay.
module ocam_core (
   input  wire        i_clk_sys,
   input  wire        i_rstn,
   input  wire        i_over,
   input  wire        i_latch_sel,
   input  wire        i_enable,
   input  wire [1:0]  i_delay_sel,
   output reg         o_alert_n,
   output reg         o_alert_oe,
   output reg         o_active
);
   localparam [`OCAM_CNT_W-1:0] DIS_LAST = `OCAM_DIS_CYC - 1;
   localparam [`OCAM_CNT_W-1:0] ENA_LAST = `OCAM_ENA_CYC - 1;
   localparam [`OCAM_CNT_W-1:0] TMR_ZERO = {`OCAM_CNT_W{1'b0}};
   localparam [`OCAM_CNT_W-1:0] TMR_ONE  = {{(`OCAM_CNT_W-1){1'b0}}, 1'b1};

   // Power states.
   localparam [1:0] ST_OFF   = `OCAM_ST_OFF;
   localparam [1:0] ST_WAKE  = `OCAM_ST_WAKE;
   localparam [1:0] ST_ON    = `OCAM_ST_ON;
   localparam [1:0] ST_SLEEP = `OCAM_ST_SLEEP;

   // The shared timer is wide enough for the long wake count; the shorter
   // shutdown count reuses it since the two states never overlap.
   wire                   win_end;
   wire                   win_over;
   reg  [1:0]             st_q;
   reg  [1:0]             st_d;
   reg  [`OCAM_CNT_W-1:0] tmr_q;
   reg  [`OCAM_CNT_W-1:0] tmr_d;
   reg  [3:0]             nwin_q;
   reg  [3:0]             nwin_d;
   reg  [3:0]             need;
   reg                    alert_q;
   reg                    alert_d;
   reg                    active;

   // The window runs from reset regardless of the power state, so its
   // phase is unrelated to the input; the alert delay varies by up to
   // one window because of that.

   ocam_window u_win (
      .i_clk_sys  (i_clk_sys),
      .i_rstn     (i_rstn),
      .i_over     (i_over),
      .o_end      (win_end),
      .o_over_avg (win_over)
   );

   // Code 3 on the delay input is not a defined setting; it falls back to
   // the shortest delay so that a stray code still raises alerts.
   always @* begin
      case (i_delay_sel)
         `OCAM_DLY_10US: begin
            need = `OCAM_NWIN_10US;
         end
         `OCAM_DLY_50US: begin
            need = `OCAM_NWIN_50US;
         end
         `OCAM_DLY_100US: begin
            need = `OCAM_NWIN_100US;
         end
         default: begin
            need = `OCAM_NWIN_10US;
         end
      endcase
   end

   // Monitoring continues through the 20 us shutdown delay, as the device
   // is still powered until it actually enters the low-power state.
   always @* begin
      case (st_q)
         ST_ON:    active = 1'b1;
         ST_SLEEP: active = 1'b1;
         default:  active = 1'b0;
      endcase
   end

   // Power state machine, next state. Each timer runs only inside its own
   // state, so a bounce on the enable input restarts the delay from zero
   // instead of shortening it. A fall during wake-up drops straight back
   // to off, and a rise during shutdown returns straight to monitoring.
   always @* begin
      st_d  = st_q;
      tmr_d = TMR_ZERO;
      case (st_q)
         // Low power: wait for the enable input.
         ST_OFF: begin
            if (i_enable) begin
               st_d = ST_WAKE;
            end
         end
         // Wake-up delay before monitoring resumes.
         ST_WAKE: begin
            if (!i_enable) begin
               st_d = ST_OFF;
            end else if (tmr_q == ENA_LAST) begin
               st_d = ST_ON;
            end else begin
               tmr_d = tmr_q + TMR_ONE;
            end
         end
         // Normal monitoring.
         ST_ON: begin
            if (!i_enable) begin
               st_d = ST_SLEEP;
            end
         end
         // Shutdown delay; monitoring still runs here.
         ST_SLEEP: begin
            if (i_enable) begin
               st_d = ST_ON;
            end else if (tmr_q == DIS_LAST) begin
               st_d = ST_OFF;
            end else begin
               tmr_d = tmr_q + TMR_ONE;
            end
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         st_q  <= ST_OFF;
         tmr_q <= TMR_ZERO;
      end else begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
      end
   end

   // Alert decision, made only at window ends while active. The window
   // count saturates at the required number so that a long overcurrent
   // cannot wrap the counter and drop a held alert in transparent mode.
   // An under window always clears the count, as the windows must be
   // consecutive.
   always @* begin
      nwin_d  = nwin_q;
      alert_d = alert_q;
      if (!active) begin
         nwin_d  = 4'h0;
         alert_d = 1'b0;
      end else if (win_end) begin
         if (win_over) begin
            if (nwin_q + 4'h1 >= need) begin
               nwin_d  = need;
               alert_d = 1'b1;
            end else begin
               nwin_d = nwin_q + 4'h1;
            end
         end else begin
            nwin_d = 4'h0;
            // Latch-select low gives transparent release; high holds.
            if (!i_latch_sel) begin
               alert_d = 1'b0;
            end
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         nwin_q  <= 4'h0;
         alert_q <= 1'b0;
      end else begin
         nwin_q  <= nwin_d;
         alert_q <= alert_d;
      end
   end

   // A latched alert whose input is already under releases at the next
   // window end after latch-select drops, so a 20 us low always clears it.
   // A shorter low pulse that misses every window end leaves the alert
   // held, which is the price of deciding only once per window.

   // The pin enable and the pin value are both registered from the same
   // bit, so the open-drain driver never glitches between them.
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_alert_n  <= 1'b1;
         o_alert_oe <= 1'b0;
         o_active   <= 1'b0;
      end else begin
         o_alert_n  <= ~alert_q;
         o_alert_oe <= alert_q;
         o_active   <= active;
      end
   end
endmodule // ocam_core

// ### tb/ocam_core_asserts.sv
module ocam_core_asserts (
   input logic i_clk_sys,
   input logic i_rstn,
   input logic i_latch_sel,
   input logic i_enable,
   input logic o_alert_n,
   input logic o_alert_oe,
   input logic o_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   property p_pin; o_alert_oe == !o_alert_n; endproperty
   a_pin: assert property (p_pin) else $error("pin enable mismatch");
   property p_idle; !o_active [*3] |-> o_alert_n; endproperty
   a_idle: assert property (p_idle) else $error("alert while idle");
   property p_wake; $rose(i_enable) && !o_active |=> !o_active [*8]; endproperty
   a_wake: assert property (p_wake) else $error("wake too fast");
   property p_slp; $fell(i_enable) && o_active |=> o_active [*8]; endproperty
   a_slp: assert property (p_slp) else $error("sleep too fast");
   property p_off; $fell(o_active) |-> !i_enable; endproperty
   a_off: assert property (p_off) else $error("sleep while enabled");
   property p_src; $fell(o_alert_n) |-> o_active; endproperty
   a_src: assert property (p_src) else $error("alert while off");
   property p_hold;
      (i_latch_sel && o_active) [*3] ##0 !o_alert_n |=> !o_alert_n;
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_rel;
      $rose(o_alert_n) |-> !$past(i_latch_sel, 2) || !$past(o_active);
   endproperty
   a_rel: assert property (p_rel) else $error("release in latch");
   c_alert: cover property ($fell(o_alert_n));
   c_on: cover property ($rose(o_active));
   c_off: cover property ($fell(o_active));
endmodule // ocam_core_asserts
bind ocam_core ocam_core_asserts ocam_core_asserts_i (.*);

// ### tb/ocam_ctrl_model.sv
module ocam_ctrl_model (
   input  logic i_clk_sys,
   input  logic i_latch_req,
   input  logic i_en_req,
   output logic o_latch_sel,
   output logic o_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   int lo_cnt = 0;
   initial begin
      o_latch_sel = 1'b0;
      o_enable = 1'b0;
   end
   // A clear pulse is stretched so it always spans a window end.
   always @(posedge i_clk_sys) begin
      lo_cnt <= o_latch_sel ? 0 : lo_cnt + 1;
      o_latch_sel <= #1 i_latch_req && (o_latch_sel || lo_cnt >= 5000);
      o_enable <= #1 i_en_req;
   end
endmodule // ocam_ctrl_model

// ### tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk_sys = 1'b0;
   logic       i_rstn = 1'b0;
   logic       i_over = 1'b0;
   logic [1:0] i_delay_sel = 2'h0;
   logic       latch_req = 1'b0;
   logic       en_req = 1'b0;
   wire        i_latch_sel, i_enable, o_alert_n, o_alert_oe, o_active;
   wire        alert_pin = o_alert_oe ? 1'b0 : 1'b1;
   int         failures = 0;
   int         checks = 0;
   int         n;
   always #2 i_clk_sys = ~i_clk_sys;
   ocam_core ocam_core_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_over(i_over), .i_latch_sel(i_latch_sel), .i_enable(i_enable),
      .i_delay_sel(i_delay_sel), .o_alert_n(o_alert_n),
      .o_alert_oe(o_alert_oe), .o_active(o_active));
   ocam_ctrl_model ocam_ctrl_model_i (.i_clk_sys(i_clk_sys),
      .i_latch_req(latch_req), .i_en_req(en_req),
      .o_latch_sel(i_latch_sel), .o_enable(i_enable));
   task automatic chk(string name, logic exp, logic got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_alert(string name, logic exp_n);
      chk({name, "_pin"}, exp_n, alert_pin);
      chk({name, "_n"}, exp_n, o_alert_n);
   endtask
   task automatic test_power_up();
      en_req = 1'b1;
      n = 0;
      while (o_active !== 1'b1 && n < 76000) begin
         cyc(1);
         n++;
      end
      chk("o_active", 1'b1, o_active);
      if (o_active !== 1'b1) end_sim();
      chk("wake_len", 1'b1, n >= 74990 && n <= 75010);
      chk_alert("alert_idle", 1'b1);
      $display("test power_up done");
   endtask
   task automatic test_latch();
      latch_req = 1'b1;
      i_over = 1'b1;
      n = 0;
      while (alert_pin !== 1'b0 && n < 5100) begin
         cyc(1);
         n++;
      end
      chk_alert("alert_set", 1'b0);
      if (alert_pin !== 1'b0) end_sim();
      i_over = 1'b0;
      cyc(2600);
      chk_alert("alert_held", 1'b0);
      i_over = 1'b1;
      latch_req = 1'b0;
      cyc(2600);
      chk_alert("alert_over", 1'b0);
      i_over = 1'b0;
      cyc(2400);
      chk_alert("alert_clr", 1'b1);
      $display("test latch done");
   endtask
   task automatic test_delay();
      i_delay_sel = 2'h1;
      i_over = 1'b1;
      cyc(9800);
      chk_alert("alert_early", 1'b1);
      cyc(2700);
      chk_alert("alert_five", 1'b0);
      $display("test delay done");
   endtask
   task automatic test_disable();
      en_req = 1'b0;
      cyc(4990);
      chk("still_on", 1'b1, o_active);
      cyc(20);
      chk("asleep", 1'b0, o_active);
      cyc(2);
      chk_alert("alert_off", 1'b1);
      cyc(2600);
      chk_alert("alert_quiet", 1'b1);
      $display("test disable done");
   endtask
   initial begin
      cyc(10);
      i_rstn = 1'b1;
      chk_alert("reset", 1'b1);
      chk("reset_active", 1'b0, o_active);
      test_power_up();
      test_latch();
      test_delay();
      test_disable();
      end_sim();
   end
endmodule // tb
